// ===== oerc_device.sv
// Output enable, range and reset control of the current output driver
// Assumes the controller end on the link; pins arrive as async levels
//
// The placing of the registers and the APB register port are this design's own decisions.
module oerc_device (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	oerc_link_if.dev         lnk,
	output oerc_pkg::oerc_drv_t iout_state,
	output logic [3:0]       iout_range,
	output logic             iout_clear_level,
	output logic             hw_mode
);
	import oerc_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers and agreement filter
	// ------------------------------------------------------------
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] sync1_ff;
	logic [PIN_W-1:0] sync2_ff;
	logic [PIN_W-1:0] sync3_ff;
	logic [PIN_W-1:0] flt_ff;

	assign pin_raw = {lnk.pin_hardware_mode_select, lnk.pin_reset_n,
		lnk.pin_clear, lnk.pin_clear_level_select,
		lnk.pin_output_drive_enable, lnk.pin_range_select};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					sync1_ff[gi] <= PIN_VEC_RST[gi];
					sync2_ff[gi] <= PIN_VEC_RST[gi];
					sync3_ff[gi] <= PIN_VEC_RST[gi];
					flt_ff[gi]   <= PIN_VEC_RST[gi];
				end else begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
					sync3_ff[gi] <= sync2_ff[gi];
					if (sync2_ff[gi] == sync3_ff[gi]) begin
						flt_ff[gi] <= sync3_ff[gi];
					end
				end
			end
		end
	endgenerate

	logic [3:0] f_range;
	logic       f_en;
	logic       f_clr_lvl;
	logic       f_clear;
	logic       f_reset_n;
	logic       f_hwsel;

	assign f_range   = flt_ff[3:0];
	assign f_en      = flt_ff[4];
	assign f_clr_lvl = flt_ff[5];
	assign f_clear   = flt_ff[6];
	assign f_reset_n = flt_ff[7];
	assign f_hwsel   = flt_ff[8];

	// ------------------------------------------------------------
	// Power-up mode sensing and reset sequencing
	// ------------------------------------------------------------
	oerc_state_t state_ff;
	oerc_state_t nxt_state;
	logic [3:0]  sense_cnt_ff;
	logic        hw_mode_ff;
	logic        reset_bit_ff;
	logic        sw_reset_req;

	// Reset pin and reset bit only count in software mode
	assign sw_reset_req = ~hw_mode_ff & (~f_reset_n | reset_bit_ff);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sense_cnt_ff <= 4'h0;
		end else if (state_ff == ST_SENSE) begin
			sense_cnt_ff <= sense_cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hw_mode_ff <= 1'b0;
		end else if (state_ff == ST_SENSE && sense_cnt_ff == SENSE_CYC) begin
			hw_mode_ff <= f_hwsel;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_SENSE: begin
				if (sense_cnt_ff == SENSE_CYC) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sw_reset_req) begin
					nxt_state = ST_RESET;
				end
			end
			ST_RESET: begin
				if (f_reset_n) begin
					nxt_state = ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_SENSE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= ST_SENSE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	logic [3:0] range_ff;
	logic       drv_en_ff;
	logic       clr_lvl_ff;
	logic       rset_ff;
	logic       wr_ok;

	assign wr_ok = lnk.wr_stb & ~hw_mode_ff & (state_ff == ST_RUN)
		& ~sw_reset_req;

	always_ff @(posedge ref_clk) begin
		if (rst || state_ff == ST_SENSE) begin
			range_ff   <= 4'h0;
			drv_en_ff  <= 1'b0;
			clr_lvl_ff <= 1'b0;
			rset_ff    <= 1'b0;
		end else if (state_ff == ST_RESET) begin
			range_ff   <= 4'h0;
			drv_en_ff  <= 1'b0;
			clr_lvl_ff <= 1'b0;
			rset_ff    <= 1'b0;
		end else if (wr_ok) begin
			range_ff   <= lnk.wr_range_select;
			drv_en_ff  <= lnk.wr_output_drive_enable;
			clr_lvl_ff <= lnk.wr_clear_level_select;
			rset_ff    <= lnk.wr_rset;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || state_ff == ST_SENSE) begin
			reset_bit_ff <= 1'b0;
		end else if (state_ff == ST_RESET) begin
			reset_bit_ff <= 1'b0;
		end else if (wr_ok) begin
			reset_bit_ff <= lnk.wr_reset;
		end
	end

	// ------------------------------------------------------------
	// Output drive state
	// ------------------------------------------------------------
	oerc_drv_t  nxt_drv;
	logic [3:0] nxt_range;
	logic       nxt_clr_level;
	logic       en_eff;
	oerc_drv_t  drv_ff;
	logic [3:0] drv_range_ff;
	logic       clr_level_ff;

	always_comb begin
		en_eff        = hw_mode_ff ? f_en : drv_en_ff;
		nxt_range     = hw_mode_ff ? f_range : range_ff;
		nxt_clr_level = f_clr_lvl | (~hw_mode_ff & clr_lvl_ff);
		// A pending reset keeps the output off, no enable glitch
		if (state_ff != ST_RUN || sw_reset_req) begin
			nxt_drv = DRV_HIZ;
		end else if (!en_eff) begin
			nxt_drv = DRV_HIZ;
		end else if (f_clear) begin
			nxt_drv = DRV_CLEAR;
		end else begin
			nxt_drv = DRV_NORMAL;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drv_ff       <= DRV_HIZ;
			drv_range_ff <= 4'h0;
			clr_level_ff <= 1'b0;
		end else begin
			drv_ff       <= nxt_drv;
			drv_range_ff <= nxt_range;
			clr_level_ff <= nxt_clr_level;
		end
	end

	logic in_reset_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			in_reset_ff <= 1'b1;
		end else begin
			in_reset_ff <= (nxt_state != ST_RUN);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign iout_state           = drv_ff;
	assign iout_range           = drv_range_ff;
	assign iout_clear_level     = clr_level_ff;
	assign hw_mode              = hw_mode_ff;
	assign lnk.drv_state        = drv_ff;
	assign lnk.drv_range        = drv_range_ff;
	assign lnk.drv_clear_level  = clr_level_ff;
	assign lnk.dev_hw_mode      = hw_mode_ff;
	assign lnk.dev_in_reset     = in_reset_ff;
	assign lnk.rb_reset_bit     = reset_bit_ff;
	assign lnk.rb_rset          = rset_ff;

endmodule

// ===== oerc_host.sv
// Controller end: APB registers drive control writes and pins
// Assumes an APB master on ref_clk and the device end on the link
module oerc_host (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	oerc_link_if.host        lnk
);
	import oerc_pkg::*;

	function automatic logic range_ok(input logic [3:0] r);
		range_ok = (r == RANGE_4_20) || (r == RANGE_0_24);
	endfunction

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic acc;
	logic hit_ctrl;
	logic hit_pins;
	logic hit_stat;
	logic [31:0] ctrl_ff;
	logic [31:0] pins_ff;
	logic        err_ff;
	logic        stb_ff;
	logic [31:0] rdata_ff;
	logic [31:0] stat;
	logic        bad_wr;

	assign hit_ctrl = (paddr == ADDR_CTRL);
	assign hit_pins = (paddr == ADDR_PINS);
	assign hit_stat = (paddr == ADDR_STAT);
	assign acc      = psel & penable;
	assign pready   = acc;
	assign pslverr  = acc & ~(hit_ctrl | hit_pins | hit_stat);
	assign prdata   = rdata_ff;
	assign bad_wr   = acc & pwrite & hit_ctrl
		& ~range_ok(pwdata[CTRL_RANGE_LSB +: 4]);

	assign stat = {18'h0, lnk.drv_state, err_ff, lnk.rb_rset,
		lnk.rb_reset_bit, lnk.dev_in_reset, lnk.dev_hw_mode,
		lnk.drv_clear_level, (lnk.drv_state == DRV_CLEAR),
		(lnk.drv_state != DRV_HIZ), lnk.drv_range};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (hit_ctrl) begin
				rdata_ff <= ctrl_ff;
			end else if (hit_pins) begin
				rdata_ff <= pins_ff;
			end else if (hit_stat) begin
				rdata_ff <= stat;
			end else begin
				rdata_ff <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------
	// Control word: one write carries enable and range together
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RST;
			stb_ff  <= 1'b0;
		end else begin
			stb_ff <= 1'b0;
			if (acc && pwrite && hit_ctrl && !bad_wr) begin
				ctrl_ff <= {24'h0, pwdata[7:0]};
				stb_ff  <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_ff <= 1'b0;
		end else if (bad_wr) begin
			err_ff <= 1'b1;
		end else if (acc && pwrite && hit_stat && pwdata[STAT_ERR]) begin
			err_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pin levels
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pins_ff <= PINS_RST;
		end else if (acc && pwrite && hit_pins) begin
			pins_ff <= {23'h0, pwdata[8:0]};
			if (pwdata[3:0] != pins_ff[3:0]) begin
				pins_ff[PIN_EN] <= 1'b0;
			end
		end
	end

	assign lnk.wr_stb                 = stb_ff;
	assign lnk.wr_range_select        = ctrl_ff[CTRL_RANGE_LSB +: 4];
	assign lnk.wr_output_drive_enable = ctrl_ff[CTRL_DRV_EN];
	assign lnk.wr_clear_level_select  = ctrl_ff[CTRL_CLR_LVL];
	assign lnk.wr_rset                = ctrl_ff[CTRL_RSET];
	assign lnk.wr_reset               = ctrl_ff[CTRL_RESET];
	assign lnk.pin_range_select       = pins_ff[PIN_RANGE_LSB +: 4];
	assign lnk.pin_output_drive_enable = pins_ff[PIN_EN];
	assign lnk.pin_clear_level_select = pins_ff[PIN_CLR_LVL];
	assign lnk.pin_clear              = pins_ff[PIN_CLEAR];
	assign lnk.pin_reset_n            = pins_ff[PIN_RESET_N]
		| pins_ff[PIN_HWSEL];
	assign lnk.pin_hardware_mode_select = pins_ff[PIN_HWSEL];

endmodule

// ===== oerc_link_if.sv
// Link between the controller and the output driver control logic
// Assumes both ends run on the same ref_clk; pins are levels
interface oerc_link_if;
	import oerc_pkg::*;

	logic            wr_stb;
	logic [3:0]      wr_range_select;
	logic            wr_output_drive_enable;
	logic            wr_clear_level_select;
	logic            wr_rset;
	logic            wr_reset;
	logic [3:0]      pin_range_select;
	logic            pin_output_drive_enable;
	logic            pin_clear_level_select;
	logic            pin_clear;
	logic            pin_reset_n;
	logic            pin_hardware_mode_select;
	oerc_drv_t       drv_state;
	logic [3:0]      drv_range;
	logic            drv_clear_level;
	logic            dev_hw_mode;
	logic            dev_in_reset;
	logic            rb_reset_bit;
	logic            rb_rset;

	modport dev (
		input  wr_stb, wr_range_select, wr_output_drive_enable,
		input  wr_clear_level_select, wr_rset, wr_reset,
		input  pin_range_select, pin_output_drive_enable,
		input  pin_clear_level_select, pin_clear, pin_reset_n,
		input  pin_hardware_mode_select,
		output drv_state, drv_range, drv_clear_level, dev_hw_mode,
		output dev_in_reset, rb_reset_bit, rb_rset
	);

	modport host (
		output wr_stb, wr_range_select, wr_output_drive_enable,
		output wr_clear_level_select, wr_rset, wr_reset,
		output pin_range_select, pin_output_drive_enable,
		output pin_clear_level_select, pin_clear, pin_reset_n,
		output pin_hardware_mode_select,
		input  drv_state, drv_range, drv_clear_level, dev_hw_mode,
		input  dev_in_reset, rb_reset_bit, rb_rset
	);

endinterface

// ===== oerc_link_sva.sv
// Checker for the output enable and reset control link
// Assumes one clock ref_clk and the device end's synchronous reset rst
module oerc_link_sva (
	input wire logic             ref_clk,
	input wire logic             rst,
	input wire logic             wr_stb,
	input wire logic [3:0]       wr_range_select,
	input wire logic             wr_output_drive_enable,
	input wire logic             wr_reset,
	input wire logic [3:0]       pin_range_select,
	input wire logic             pin_output_drive_enable,
	input wire logic             pin_clear,
	input wire logic             pin_reset_n,
	input wire oerc_pkg::oerc_drv_t drv_state,
	input wire logic [3:0]       drv_range,
	input wire logic             dev_hw_mode,
	input wire logic             dev_in_reset,
	input wire logic             rb_reset_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	import oerc_pkg::*;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic sw_cond;
	assign sw_cond = wr_stb && !dev_hw_mode && !dev_in_reset && pin_reset_n;

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	sequence sense_done;
		dev_in_reset [*4] ##[1:6] !dev_in_reset;
	endsequence

	sequence bit_reset_seq;
		##[1:3] drv_state == DRV_HIZ ##[1:6] (!dev_in_reset && !rb_reset_bit);
	endsequence

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	reset_state_a: assert property (
		$fell(rst) |-> drv_state == DRV_HIZ && drv_range == 4'h0)
		else $error("output not idle after reset");
	mode_sense_a: assert property ($fell(rst) |-> sense_done)
		else $error("mode sensing did not finish");
	sw_disable_a: assert property (
		sw_cond && !wr_reset && !wr_output_drive_enable
		|-> ##2 drv_state == DRV_HIZ)
		else $error("disable write did not tristate");
	sw_enable_a: assert property (
		sw_cond && !wr_reset && wr_output_drive_enable && !pin_clear
		|-> ##2 drv_state == DRV_NORMAL
		&& drv_range == $past(wr_range_select, 2))
		else $error("enable write not applied with range");
	sw_clear_a: assert property (
		sw_cond && !wr_reset && wr_output_drive_enable && pin_clear
		|-> ##2 drv_state == DRV_CLEAR)
		else $error("enable under clear did not clear");
	bit_reset_a: assert property (
		sw_cond && wr_reset |-> bit_reset_seq)
		else $error("reset bit not executed");
	pin_reset_a: assert property (
		(!dev_hw_mode && !pin_reset_n) [*8]
		|-> dev_in_reset && drv_state == DRV_HIZ)
		else $error("low reset pin not holding reset");
	hw_off_a: assert property (
		(dev_hw_mode && !pin_output_drive_enable) [*8]
		|-> drv_state == DRV_HIZ)
		else $error("hardware disable not tristate");
	hw_on_a: assert property (
		(dev_hw_mode && pin_output_drive_enable && !pin_clear) [*8]
		|-> drv_state == DRV_NORMAL && drv_range == pin_range_select)
		else $error("hardware pins not applied");
	hw_noreset_a: assert property (
		dev_hw_mode |-> pin_reset_n && !rb_reset_bit)
		else $error("reset active in hardware mode");
endmodule

// ===== oerc_pkg.sv
// Shared constants for the output enable and reset control link
// Assumes one clock, ref_clk at 100 MHz, and a synchronous active-high reset
package oerc_pkg;

	// ------------------------------------------------------------
	// Host register map (APB byte addresses)
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] ADDR_PINS = 32'h0000_0004;
	localparam logic [31:0] ADDR_STAT = 32'h0000_0008;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTRL_RANGE_LSB = 0;
	localparam int CTRL_DRV_EN    = 4;
	localparam int CTRL_CLR_LVL   = 5;
	localparam int CTRL_RSET      = 6;
	localparam int CTRL_RESET     = 7;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// ------------------------------------------------------------
	// Pin register fields
	// ------------------------------------------------------------
	localparam int PIN_RANGE_LSB = 0;
	localparam int PIN_EN        = 4;
	localparam int PIN_CLR_LVL   = 5;
	localparam int PIN_CLEAR     = 6;
	localparam int PIN_RESET_N   = 7;
	localparam int PIN_HWSEL     = 8;
	localparam logic [31:0] PINS_RST = 32'h0000_0080;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int STAT_RANGE_LSB = 0;
	localparam int STAT_ENABLED   = 4;
	localparam int STAT_CLEAR     = 5;
	localparam int STAT_CLR_LEVEL = 6;
	localparam int STAT_HW_MODE   = 7;
	localparam int STAT_IN_RESET  = 8;
	localparam int STAT_RESET_BIT = 9;
	localparam int STAT_RSET      = 10;
	localparam int STAT_ERR       = 11;
	localparam int STAT_DRV_LSB   = 12;

	// ------------------------------------------------------------
	// Range codes, pin vector width and reset value, and power-up sensing time
	// ------------------------------------------------------------
	localparam logic [3:0] RANGE_4_20 = 4'h0;
	localparam logic [3:0] RANGE_0_24 = 4'h2;
	localparam int         PIN_W      = 9;
	localparam logic [8:0] PIN_VEC_RST = 9'h080;
	localparam logic [3:0] SENSE_CYC  = 4'h4;

	typedef enum logic [1:0] {
		DRV_HIZ    = 2'b00,
		DRV_NORMAL = 2'b01,
		DRV_CLEAR  = 2'b10
	} oerc_drv_t;

	typedef enum logic [1:0] {
		ST_SENSE = 2'b00,
		ST_RUN   = 2'b01,
		ST_RESET = 2'b10
	} oerc_state_t;

endpackage

// ===== output_enable_reset_control_bench.sv
// Testbench for the output enable and reset control link
// Assumes oerc_host, oerc_device, oerc_link_if and oerc_link_sva
module output_enable_reset_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import oerc_pkg::*;

	typedef struct {
		logic [31:0] ctrl;
		oerc_drv_t   st;
		logic [3:0]  rng;
		logic        clr;
	} oerc_row_t;

	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        host_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        slverr;
	logic [3:0]  iout_range;
	logic        iout_clear_level;
	logic        hw_mode;
	oerc_drv_t   iout_state;
	int          err_count = 0;
	int          samples_checked = 0;
	oerc_row_t   rows [6] = '{
		'{32'h0000_0010, DRV_NORMAL, 4'h0, 1'b0},
		'{32'h0000_0012, DRV_NORMAL, 4'h2, 1'b0},
		'{32'h0000_0032, DRV_NORMAL, 4'h2, 1'b1},
		'{32'h0000_0052, DRV_NORMAL, 4'h2, 1'b0},
		'{32'h0000_0002, DRV_HIZ, 4'h2, 1'b0},
		'{32'h0000_0011, DRV_HIZ, 4'h2, 1'b0}};

	oerc_link_if lnk ();

	oerc_host i_oerc_host (.ref_clk(ref_clk), .rst(host_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));

	oerc_device i_oerc_device (.ref_clk(ref_clk), .rst(rst), .lnk(lnk),
		.iout_state(iout_state), .iout_range(iout_range),
		.iout_clear_level(iout_clear_level), .hw_mode(hw_mode));

	oerc_link_sva i_oerc_link_sva (.ref_clk(ref_clk), .rst(rst),
		.wr_stb(lnk.wr_stb), .wr_range_select(lnk.wr_range_select),
		.wr_output_drive_enable(lnk.wr_output_drive_enable),
		.wr_reset(lnk.wr_reset), .pin_range_select(lnk.pin_range_select),
		.pin_output_drive_enable(lnk.pin_output_drive_enable),
		.pin_clear(lnk.pin_clear), .pin_reset_n(lnk.pin_reset_n),
		.drv_state(lnk.drv_state), .drv_range(lnk.drv_range),
		.dev_hw_mode(lnk.dev_hw_mode), .dev_in_reset(lnk.dev_in_reset),
		.rb_reset_bit(lnk.rb_reset_bit));

	always #5 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task complete_run;
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task apb(input logic w, input logic [31:0] a, d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task expect_out(input oerc_drv_t e, input logic [3:0] r, input logic c);
		for (int n = 0; n < 16 && (iout_state !== e || iout_range !== r
			|| iout_clear_level !== c); n++) @(negedge ref_clk);
		check("iout_state", 32'(iout_state), 32'(e));
		check("iout_range", 32'(iout_range), 32'(r));
		check("iout_clear_level", 32'(iout_clear_level), 32'(c));
	endtask

	task dev_reset;
		rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		host_rst <= 1'b0;
		for (int n = 0; n < 20 && lnk.dev_in_reset !== 1'b0; n++)
			@(negedge ref_clk);
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		dev_reset();
		check("hw_mode", 32'(hw_mode), 32'h0);
		expect_out(DRV_HIZ, 4'h0, 1'b0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl", rd, CTRL_RST);
		foreach (rows[i]) begin
			apb(1'b1, ADDR_CTRL, rows[i].ctrl);
			repeat (4) @(negedge ref_clk);
			expect_out(rows[i].st, rows[i].rng, rows[i].clr);
		end
		apb(1'b0, ADDR_STAT, 32'h0);
		check("err", 32'(rd[STAT_ERR]), 32'h1);
		apb(1'b0, 32'h0000_0010, 32'h0);
		check("pslverr", 32'(slverr), 32'h1);
		check("prdata", rd, 32'h0);
		apb(1'b1, ADDR_PINS, 32'h0000_00E0);
		repeat (8) @(posedge ref_clk);
		apb(1'b1, ADDR_CTRL, 32'h0000_0010);
		expect_out(DRV_CLEAR, 4'h0, 1'b1);
		apb(1'b1, ADDR_PINS, 32'h0000_0080);
		expect_out(DRV_NORMAL, 4'h0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0000_0092);
		expect_out(DRV_HIZ, 4'h0, 1'b0);
		repeat (8) @(posedge ref_clk);
		apb(1'b0, ADDR_STAT, 32'h0);
		check("reset_bit", 32'(rd[STAT_RESET_BIT]), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0000_0010);
		expect_out(DRV_NORMAL, 4'h0, 1'b0);
		apb(1'b1, ADDR_PINS, 32'h0000_0000);
		expect_out(DRV_HIZ, 4'h0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0000_0012);
		repeat (20) @(negedge ref_clk);
		check("in_reset", 32'(lnk.dev_in_reset), 32'h1);
		apb(1'b1, ADDR_PINS, 32'h0000_0080);
		repeat (12) @(negedge ref_clk);
		expect_out(DRV_HIZ, 4'h0, 1'b0);
		apb(1'b1, ADDR_PINS, 32'h0000_0180);
		dev_reset();
		check("hw_mode", 32'(hw_mode), 32'h1);
		apb(1'b1, ADDR_PINS, 32'h0000_0102);
		@(negedge ref_clk);
		check("pin_reset_n", 32'(lnk.pin_reset_n), 32'h1);
		expect_out(DRV_HIZ, 4'h2, 1'b0);
		apb(1'b1, ADDR_PINS, 32'h0000_0192);
		expect_out(DRV_NORMAL, 4'h2, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
		repeat (8) @(negedge ref_clk);
		expect_out(DRV_NORMAL, 4'h2, 1'b0);
		apb(1'b1, ADDR_PINS, 32'h0000_0190);
		expect_out(DRV_HIZ, 4'h0, 1'b0);
		complete_run();
	end

	initial begin
		#50us;
		err_count++;
		complete_run();
	end
endmodule
